// ==== conv_ready.sv ====
`timescale 1ns/100ps
module conv_ready
    import conv_ready_pkg::*;
#(
    parameter int WORD_W = DATA_W
)(
    input  wire logic              clock_i,
    input  wire logic              srst_i,
    input  wire logic              standby_n_i,
    input  wire logic              cs_n_i,
    input  wire logic              sclk_i,
    input  wire logic              sdin_i,
    output logic                   sdout_o,
    output logic                   ready_n_o,
    input  wire logic              result_valid_i,
    input  wire logic [WORD_W-1:0] result_i,
    input  wire logic              bipolar_i,
    input  wire logic              update_soon_i,
    input  wire logic              cal_start_i,
    input  wire logic              cal_done_i,
    output logic                   cal_busy_o,
    output logic [REG_W-1:0]       mode_o,
    output logic [REG_W-1:0]       filter_o
);
    ser_state_t        st_q, st_d;
    logic [7:0]        comm_q, comm_d;
    logic [REG_W-1:0]  mode_q, mode_d, filt_q, filt_d;
    logic [REG_W-1:0]  offs_q, offs_d, gain_q, gain_d;
    logic [REG_W-1:0]  data_q, data_d;
    logic [REG_W-1:0]  sh_q, sh_d;
    logic [4:0]        cnt_q, cnt_d;
    logic              rdy_n_q, rdy_n_d, cal_q, cal_d, sclk_q, sdo_q, sdo_d;
    logic              rise, fall, run;
    logic [REG_W-1:0]  outsel, status;
    logic [4:0]        len;
    logic              read_done;

    assign run  = standby_n_i;
    assign rise = sclk_i & ~sclk_q & ~cs_n_i;
    assign fall = ~sclk_i & sclk_q & ~cs_n_i;
    assign status = {{(REG_W-2){1'b0}}, cal_q, rdy_n_q};
    assign len = (comm_q[2:0] == SEL_DATA) ? 5'(WORD_W) : 5'(REG_W);

    always_comb
    begin
        case (comm_q[2:0])
            SEL_STATUS: outsel = status;
            SEL_DATA:   outsel = data_q;
            SEL_MODE:   outsel = mode_q;
            SEL_FILTER: outsel = filt_q;
            SEL_OFFS:   outsel = offs_q;
            SEL_GAIN:   outsel = gain_q;
            default:    outsel = status;
        endcase
    end

    // ready and calibration flags; priority cal start, cal done,
    // update warning, new result, then a finished data read
    always_comb
    begin
        rdy_n_d = rdy_n_q;
        cal_d = cal_q;
        data_d = data_q;
        if (run)
        begin
            if (cal_start_i)
            begin
                cal_d = 1'b1;
                rdy_n_d = 1'b1;
            end
            else if (cal_q && cal_done_i)
            begin
                cal_d = 1'b0;
                rdy_n_d = 1'b0;
            end
            else if (!cal_q && update_soon_i)
            begin
                rdy_n_d = 1'b1;
            end
            else if (!cal_q && result_valid_i)
            begin
                // offset binary: flip top bit of two's complement
                data_d = REG_W'(bipolar_i ?
                    {~result_i[WORD_W-1], result_i[WORD_W-2:0]} :
                    result_i);
                rdy_n_d = 1'b0;
            end
            else if (!cal_q && read_done)
            begin
                // a fresh result in the same cycle keeps ready low
                rdy_n_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            rdy_n_q <= 1'b1;
            cal_q <= 1'b0;
            data_q <= REG_RESET;
        end
        else
        begin
            rdy_n_q <= rdy_n_d;
            cal_q <= cal_d;
            data_q <= data_d;
        end
    end

    // serial port: comm byte, then one register word in or out, except a select 0 write, which ends after the comm byte
    always_comb
    begin
        st_d = st_q;
        comm_d = comm_q;
        mode_d = mode_q;
        filt_d = filt_q;
        offs_d = offs_q;
        gain_d = gain_q;
        sh_d = sh_q;
        cnt_d = cnt_q;
        sdo_d = sdo_q;
        read_done = 1'b0;
        if (run)
        begin
            case (st_q)
                ST_IDLE:
                    if (rise)
                    begin
                        sh_d = {sh_q[REG_W-2:0], sdin_i};
                        cnt_d = cnt_q + 5'd1;
                        if (cnt_q == 5'd7)
                        begin
                            comm_d = {sh_q[6:0], sdin_i};
                            cnt_d = 5'd0;
                            if (sh_q[COMM_RW_BIT-1])
                            begin
                                st_d = ST_SHIFT_OUT;
                            end
                            else if ({sh_q[1:0], sdin_i} != SEL_COMM)
                            begin
                                // select 0 write only loads the comm byte
                                st_d = ST_SHIFT_IN;
                            end
                        end
                    end
                ST_SHIFT_IN:
                    if (rise)
                    begin
                        sh_d = {sh_q[REG_W-2:0], sdin_i};
                        cnt_d = cnt_q + 5'd1;
                        if (cnt_q == len - 5'd1)
                        begin
                            case (comm_q[2:0])
                                SEL_MODE:   mode_d = sh_d;
                                SEL_FILTER: filt_d = sh_d;
                                SEL_OFFS:   offs_d = sh_d;
                                SEL_GAIN:   gain_d = sh_d;
                                default:    ;
                            endcase
                            cnt_d = 5'd0;
                            st_d = ST_IDLE;
                        end
                    end
                ST_SHIFT_OUT:
                    if (fall)
                    begin
                        sh_d = (cnt_q == 5'd0) ? outsel << (REG_W - len)
                                               : sh_q << 1;
                        sdo_d = sh_d[REG_W-1];
                    end
                    else if (rise)
                    begin
                        cnt_d = cnt_q + 5'd1;
                        if (cnt_q == len - 5'd1)
                        begin
                            cnt_d = 5'd0;
                            st_d = ST_IDLE;
                            if (comm_q[2:0] == SEL_DATA)
                            begin
                                read_done = 1'b1;
                            end
                        end
                    end
                default: st_d = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            st_q <= ST_IDLE;
            comm_q <= 8'h00;
            mode_q <= REG_RESET;
            filt_q <= REG_RESET;
            offs_q <= REG_RESET;
            gain_q <= REG_RESET;
            sh_q <= REG_RESET;
            cnt_q <= 5'd0;
            // idle level of sclk is high: no false edge after reset
            sclk_q <= 1'b1;
            sdo_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            comm_q <= comm_d;
            mode_q <= mode_d;
            filt_q <= filt_d;
            offs_q <= offs_d;
            gain_q <= gain_d;
            sh_q <= sh_d;
            cnt_q <= cnt_d;
            sclk_q <= sclk_i;
            sdo_q <= sdo_d;
        end
    end

    assign sdout_o   = sdo_q;
    assign ready_n_o = rdy_n_q;
    assign cal_busy_o = cal_q;
    assign mode_o    = mode_q;
    assign filter_o  = filt_q;
endmodule : conv_ready

// ==== conv_ready_pkg.sv ====
package conv_ready_pkg;
    localparam int DATA_W   = 24;
    localparam int REG_W    = 24;
    localparam int SEL_W    = 3;
    // register select codes
    localparam logic [2:0] SEL_COMM   = 3'h0;
    localparam logic [2:0] SEL_STATUS = 3'h0;
    localparam logic [2:0] SEL_DATA   = 3'h1;
    localparam logic [2:0] SEL_MODE   = 3'h2;
    localparam logic [2:0] SEL_FILTER = 3'h3;
    localparam logic [2:0] SEL_OFFS   = 3'h5;
    localparam logic [2:0] SEL_GAIN   = 3'h6;
    localparam int COMM_RW_BIT = 3;
    // time ready rises ahead of an update
    localparam int LEAD_NS      = 40;
    localparam int CLK_NS       = 4;
    localparam int LEAD_CYCLES  = (LEAD_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [23:0] REG_RESET = 24'h00_0000;
    typedef enum logic [1:0] {ST_IDLE, ST_SHIFT_IN, ST_SHIFT_OUT} ser_state_t;
endpackage : conv_ready_pkg

// ==== conv_ready_sva.sv ====
`timescale 1ns/100ps
module conv_ready_sva import conv_ready_pkg::*;
(input wire logic clock_i, srst_i, standby_n_i, cs_n_i, result_valid_i,
    update_soon_i, cal_start_i, cal_done_i, ready_n_o, cal_busy_o,
    input wire logic [REG_W-1:0] mode_o);
    default clocking @(posedge clock_i); endclocking
    default disable iff (srst_i);
    a_result_ready: assert property (result_valid_i && standby_n_i
        && !cal_busy_o && !cal_start_i && !update_soon_i
        |=> !ready_n_o) else $error("ready");
    a_update_lift: assert property (update_soon_i && standby_n_i
        && !cal_busy_o |=> ready_n_o) else $error("lift");
    a_cal_busy: assert property (cal_start_i && standby_n_i
        |-> ##[1:2] cal_busy_o && ready_n_o) else $error("busy");
    a_cal_end: assert property (cal_done_i && cal_busy_o
        && standby_n_i && !cal_start_i
        |=> !cal_busy_o && !ready_n_o) else $error("end");
    a_busy_cause: assert property ($fell(cal_busy_o)
        |-> $past(cal_done_i) || $past(srst_i)) else $error("fall");
    a_standby_hold: assert property (!standby_n_i
        |=> $stable(mode_o) && $stable(ready_n_o)) else $error("moved");
    a_desel_hold: assert property (cs_n_i && standby_n_i
        |=> $stable(mode_o)) else $error("write");
    a_reset_idle: assert property (disable iff (1'b0) srst_i
        |=> ready_n_o && !cal_busy_o) else $error("reset");
endmodule : conv_ready_sva
bind conv_ready conv_ready_sva sva (.*);

// ==== conversion_ready_status_tb_top.sv ====
`timescale 1ns/100ps
module conversion_ready_status_tb_top;
    logic clock_i = 1'b0, srst_i = 1'b1, standby_n_i = 1'b1, cal_busy_o;
    logic bipolar_i = 1'b1, cs_n_i, sclk_i, sdin_i, sdout_o, ready_n_o;
    logic [3:0] ev = 4'h0;
    logic [23:0] result_i = 24'hFF_FFFF, mode_o, filter_o, r;
    int failures = 0, cmp_count = 0;
    initial forever #2 clock_i = ~clock_i;
    conv_ready uut (.*, .result_valid_i(ev[0]), .update_soon_i(ev[1]),
        .cal_start_i(ev[2]), .cal_done_i(ev[3]));
    host_model host (.clock_i, .sdout_i(sdout_o), .cs_n_o(cs_n_i),
        .sclk_o(sclk_i), .sdin_o(sdin_i));
    task chk(input logic [23:0] s, e);
        cmp_count++;
        failures += int'(s !== e);
        if (s !== e) $display("BAD %0t %h %h", $time, s, e);
    endtask : chk
    task fire(input logic [3:0] e);
        @(posedge clock_i) ev <= e;
        @(posedge clock_i) ev <= 4'h0;
        repeat (3) @(posedge clock_i);
    endtask : fire
    task results;
        $display("cmp %0d fail %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results
    task t_ready;
        fire(4'h1);
        fire(4'h2);
        chk(24'(ready_n_o), 24'h1);
        fire(4'h1);
        chk(24'(ready_n_o), 24'h0);
        host.xfer({8'h09, 24'h0}, r);
        chk(r, 24'h7F_FFFF);
        chk(24'(ready_n_o), 24'h1);
        $display("ready done");
    endtask : t_ready
    task t_cal;
        host.xfer({8'h02, 24'hA5_5A5A}, r);
        fire(4'h4);
        chk(24'({cal_busy_o, ready_n_o}), 24'h3);
        fire(4'h8);
        chk(24'({cal_busy_o, ready_n_o}), 24'h0);
        @(posedge clock_i) standby_n_i <= 1'b0;
        host.xfer({8'h02, 24'h11_1111}, r);
        fire(4'h4);
        chk(24'({cal_busy_o, ready_n_o}), 24'h0);
        @(posedge clock_i) standby_n_i <= 1'b1;
        chk(mode_o, 24'hA5_5A5A);
        $display("cal done");
    endtask : t_cal
    task t_regs;
        host.xfer({8'h03, 24'h12_3456}, r);
        chk(filter_o, 24'h12_3456);
        host.xfer({8'h0B, 24'h00_0000}, r);
        chk(r, 24'h12_3456);
        host.xfer({8'h0A, 24'h00_0000}, r);
        chk(r, 24'hA5_5A5A);
        @(posedge clock_i)
        begin
            bipolar_i <= 1'b0;
            result_i <= 24'h65_4321;
        end
        fire(4'h1);
        host.xfer({8'h01, 24'h00_0000}, r);
        chk(24'(ready_n_o), 24'h0);
        host.xfer({8'h09, 24'h00_0000}, r);
        chk(r, 24'h65_4321);
        host.xfer({8'h08, 24'h00_0000}, r);
        chk(r, 24'h00_0001);
        $display("regs done");
    endtask : t_regs
    initial
    begin
        @(posedge clock_i) @(posedge clock_i) srst_i <= 1'b0;
        t_ready();
        t_cal();
        t_regs();
        results();
    end
endmodule : conversion_ready_status_tb_top

// ==== host_model.sv ====
`timescale 1ns/100ps
module host_model (input wire logic clock_i, sdout_i,
    output logic cs_n_o = 1'b1, sclk_o = 1'b1, sdin_o = 1'b0);
    // sclk stands high between frames; half period of 4 clocks
    task xfer(input logic [31:0] f, output logic [23:0] r);
        @(posedge clock_i) cs_n_o <= 1'b0;
        for (int i = 31; i >= 0; i--)
        begin
            #16 {sclk_o, sdin_o} <= {1'b0, f[i]};
            #16 sclk_o <= 1'b1;
            r = {r[22:0], sdout_i};
        end
        #16 {cs_n_o, sdin_o} <= {1'b1, ~sdin_o};
    endtask : xfer
endmodule : host_model
